// ===== common/arsx_pkg.sv
// Shared types and constants for the rotate/subtract/xor execution block
package arsx_pkg;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam logic [FADDR_W-1:0] DIR_SEL_A = 7'h05;
    localparam logic [FADDR_W-1:0] DIR_SEL_B = 7'h06;
    localparam logic [FADDR_W-1:0] DIR_SEL_C = 7'h07;
    localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
    localparam logic [DATA_W-1:0] DIR_RST = 8'hff;
    localparam logic EXPIRY_RST = 1'b1;
    localparam logic PWR_DOWN_RST = 1'b1;
    localparam int WAKE_SYNC_STAGES = 2;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_ROR = 4'h1,
        OP_LSUB = 4'h2,
        OP_FSUB = 4'h3,
        OP_FSUBB = 4'h4,
        OP_SWAP = 4'h5,
        OP_DIRLD = 4'h6,
        OP_LXOR = 4'h7,
        OP_FXOR = 4'h8,
        OP_SLEEP = 4'h9
    } arsx_op_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_HALT = 2'b10
    } arsx_state_t;

    typedef struct packed {
        logic valid;
        arsx_op_t op;
        logic [FADDR_W-1:0] faddr;
        logic dest;
        logic [DATA_W-1:0] lit;
    } arsx_req_t;

    typedef struct packed {
        logic carry;
        logic nib;
        logic zero;
        logic expiry;
        logic pwr_down;
    } arsx_stat_t;

    typedef struct packed {
        logic we;
        logic [FADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } arsx_fwr_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic carry;
        logic nib;
        logic upd_carry;
        logic upd_nib;
        logic upd_zero;
    } arsx_res_t;
endpackage

// ===== design/arsx_alu.sv
// Combinational result and flag logic for the supported operations
`timescale 1ns/1ns
module arsx_alu (
    // Operation and operands
    input wire arsx_pkg::arsx_op_t op_in,
    input wire logic [7:0] acc_in,
    input wire logic [7:0] fval_in,
    input wire logic [7:0] lit_in,
    input wire logic carry_in,
    // Result
    output arsx_pkg::arsx_res_t res_out
);
    import arsx_pkg::*;

    // Subtract by adding the complement; carry out set means no borrow
    function automatic logic [9:0] sub8(input logic [7:0] a, input logic [7:0] b,
                                        input logic cin);
        logic [8:0] full;
        logic [4:0] low;
        full = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
        low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
        return {full[8], low[4], full[7:0]};
    endfunction

    wire logic [9:0] lsub_w = sub8(lit_in, acc_in, 1'b1);
    wire logic [9:0] fsub_w = sub8(fval_in, acc_in, 1'b1);
    wire logic [9:0] fsubb_w = sub8(fval_in, acc_in, carry_in);
    wire logic [9:0] sel_w = (op_in == OP_LSUB) ? lsub_w :
                             (op_in == OP_FSUB) ? fsub_w : fsubb_w;
    wire logic is_sub = (op_in == OP_LSUB) || (op_in == OP_FSUB) || (op_in == OP_FSUBB);
    wire logic is_ror = (op_in == OP_ROR);
    wire logic is_xor = (op_in == OP_LXOR) || (op_in == OP_FXOR);

    wire logic [7:0] ror_w = {carry_in, fval_in[7:1]};
    wire logic [7:0] swap_w = {fval_in[3:0], fval_in[7:4]};
    wire logic [7:0] xor_w = acc_in ^ ((op_in == OP_LXOR) ? lit_in : fval_in);

    assign res_out.data = is_sub ? sel_w[7:0] :
                          is_ror ? ror_w :
                          is_xor ? xor_w :
                          (op_in == OP_SWAP) ? swap_w : acc_in;
    assign res_out.carry = is_ror ? fval_in[0] : sel_w[9];
    assign res_out.nib = sel_w[8];
    assign res_out.upd_carry = is_sub || is_ror;
    assign res_out.upd_nib = is_sub;
    assign res_out.upd_zero = is_sub || is_xor;
endmodule

// ===== design/arsx_exec.sv
// Execution unit: rotate, subtract, swap, xor, direction load and sleep
`timescale 1ns/1ns
module arsx_exec (
    // Clock, reset, enable
    input wire logic CORE_CLK_IN,
    input wire logic RST_IN,
    input wire logic CE_IN,
    // Decoded instruction and addressed file value
    input wire arsx_pkg::arsx_req_t REQ_IN,
    input wire logic [7:0] FILE_RDATA_IN,
    // Wake-up pin from outside the clock domain
    input wire logic WAKE_IN,
    // Core state
    output logic READY_OUT,
    output logic [7:0] ACC_OUT,
    output arsx_pkg::arsx_stat_t STATUS_OUT,
    output arsx_pkg::arsx_fwr_t FILE_WR_OUT,
    // Pin direction registers
    output logic [7:0] PORT_A_DIR_OUT,
    output logic [7:0] PORT_B_DIR_OUT,
    output logic [7:0] PORT_C_DIR_OUT,
    // Watchdog and clock control
    output logic WDOG_CLEAR_OUT,
    output logic OSC_STOP_OUT
);
    import arsx_pkg::*;

    arsx_state_t state_r;
    arsx_state_t state_nxt;
    logic [7:0] acc_r;
    logic [7:0] acc_nxt;
    arsx_stat_t stat_r;
    arsx_stat_t stat_nxt;
    arsx_fwr_t fwr_r;
    arsx_fwr_t fwr_nxt;
    logic [7:0] dir_a_r;
    logic [7:0] dir_b_r;
    logic [7:0] dir_c_r;
    logic wdog_clr_r;
    logic osc_stop_r;
    logic ready_r;
    logic wake_s1_r;
    logic wake_s2_r;
    arsx_res_t res;

    // Decode
    wire arsx_op_t op = REQ_IN.op;
    wire logic take = CE_IN && REQ_IN.valid && (state_r == ST_RUN);
    wire logic has_dest = (op == OP_ROR) || (op == OP_FSUB) || (op == OP_FSUBB) ||
                          (op == OP_SWAP) || (op == OP_FXOR);
    wire logic is_lit = (op == OP_LSUB) || (op == OP_LXOR);
    wire logic to_file = take && has_dest && REQ_IN.dest;
    wire logic to_acc = take && (is_lit || (has_dest && !REQ_IN.dest));
    wire logic dir_ld = take && (op == OP_DIRLD);
    wire logic go_sleep = take && (op == OP_SLEEP);
    wire logic upd_zero = take && res.upd_zero;
    wire logic res_zero = (res.data == 8'h00);

    arsx_alu u_alu (
        .op_in(op),
        .acc_in(acc_r),
        .fval_in(FILE_RDATA_IN),
        .lit_in(REQ_IN.lit),
        .carry_in(stat_r.carry),
        .res_out(res)
    );

    // Next state of registers
    assign acc_nxt = to_acc ? res.data : acc_r;
    assign fwr_nxt.we = to_file;
    assign fwr_nxt.addr = REQ_IN.faddr;
    assign fwr_nxt.data = res.data;
    assign stat_nxt.carry = (take && res.upd_carry) ? res.carry : stat_r.carry;
    assign stat_nxt.nib = (take && res.upd_nib) ? res.nib : stat_r.nib;
    assign stat_nxt.zero = upd_zero ? res_zero : stat_r.zero;
    assign stat_nxt.expiry = go_sleep ? 1'b1 : stat_r.expiry;
    assign stat_nxt.pwr_down = go_sleep ? 1'b0 : stat_r.pwr_down;

    // Wake from halt only on the synchronised pin level
    always_comb begin
        case (state_r)
            ST_RUN: state_nxt = go_sleep ? ST_HALT : ST_RUN;
            ST_HALT: state_nxt = wake_s2_r ? ST_RUN : ST_HALT;
            default: state_nxt = ST_RUN;
        endcase
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            wake_s1_r <= 1'b0;
            wake_s2_r <= 1'b0;
        end else if (CE_IN) begin
            wake_s1_r <= WAKE_IN;
            wake_s2_r <= wake_s1_r;
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            state_r <= ST_RUN;
            ready_r <= 1'b1;
            acc_r <= ACC_RST;
            stat_r <= '{carry: 1'b0, nib: 1'b0, zero: 1'b0,
                        expiry: EXPIRY_RST, pwr_down: PWR_DOWN_RST};
            fwr_r <= '0;
        end else if (CE_IN) begin
            state_r <= state_nxt;
            ready_r <= (state_nxt == ST_RUN);
            acc_r <= acc_nxt;
            stat_r <= stat_nxt;
            fwr_r <= fwr_nxt;
        end
    end

    // Direction registers default to all inputs
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            dir_a_r <= DIR_RST;
            dir_b_r <= DIR_RST;
            dir_c_r <= DIR_RST;
        end else if (CE_IN && dir_ld) begin
            if (REQ_IN.faddr == DIR_SEL_A) dir_a_r <= acc_r;
            if (REQ_IN.faddr == DIR_SEL_B) dir_b_r <= acc_r;
            if (REQ_IN.faddr == DIR_SEL_C) dir_c_r <= acc_r;
        end
    end

    // Watchdog clear is a one-cycle pulse; oscillator stop holds for the halt
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            wdog_clr_r <= 1'b0;
            osc_stop_r <= 1'b0;
        end else if (CE_IN) begin
            wdog_clr_r <= go_sleep;
            osc_stop_r <= (state_nxt == ST_HALT);
        end
    end

    assign READY_OUT = ready_r;
    assign ACC_OUT = acc_r;
    assign STATUS_OUT = stat_r;
    assign FILE_WR_OUT = fwr_r;
    assign PORT_A_DIR_OUT = dir_a_r;
    assign PORT_B_DIR_OUT = dir_b_r;
    assign PORT_C_DIR_OUT = dir_c_r;
    assign WDOG_CLEAR_OUT = wdog_clr_r;
    assign OSC_STOP_OUT = osc_stop_r;

    // Checks
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (RST_IN);

    wire logic [7:0] req_lit = REQ_IN.lit;
    wire logic [6:0] req_addr = REQ_IN.faddr;
    wire logic cur_carry = stat_r.carry;

    rot_right_a: assert property (
        take && op == OP_ROR |=> fwr_r.data == {$past(cur_carry), $past(FILE_RDATA_IN[7:1])}
            && stat_r.carry == $past(FILE_RDATA_IN[0])
            && stat_r.zero == $past(stat_r.zero) && stat_r.nib == $past(stat_r.nib))
        else $error("rotate right result or flags wrong");

    dest_select_a: assert property (
        take && has_dest |=> (fwr_r.we == $past(REQ_IN.dest))
            && (fwr_r.we ? (acc_r == $past(acc_r) && fwr_r.addr == $past(req_addr))
                         : acc_r == fwr_r.data))
        else $error("destination select wrong");

    lit_sub_a: assert property (
        take && op == OP_LSUB |=> acc_r == 8'($past(req_lit) - $past(acc_r))
            && stat_r.carry == ($past(acc_r) <= $past(req_lit))
            && stat_r.nib == ($past(acc_r[3:0]) <= $past(req_lit[3:0])))
        else $error("literal subtract wrong");

    file_sub_a: assert property (
        take && op == OP_FSUB |=> fwr_r.data == 8'($past(FILE_RDATA_IN) - $past(acc_r))
            && stat_r.carry == ($past(acc_r) <= $past(FILE_RDATA_IN))
            && stat_r.nib == ($past(acc_r[3:0]) <= $past(FILE_RDATA_IN[3:0])))
        else $error("file subtract wrong");

    borrow_sub_a: assert property (
        take && op == OP_FSUBB |=> fwr_r.data ==
            8'($past(FILE_RDATA_IN) - $past(acc_r) - {7'h00, !$past(cur_carry)})
            && stat_r.zero == (fwr_r.data == 8'h00))
        else $error("subtract with borrow wrong");

    nib_swap_a: assert property (
        take && op == OP_SWAP |=> fwr_r.data == {$past(FILE_RDATA_IN[3:0]),
            $past(FILE_RDATA_IN[7:4])} && $stable(stat_r))
        else $error("nibble exchange wrong");

    dir_load_a: assert property (
        take && op == OP_DIRLD && req_addr == DIR_SEL_B |=> dir_b_r == $past(acc_r)
            && $stable(dir_a_r) && $stable(dir_c_r) && $stable(stat_r))
        else $error("direction load wrong");

    lit_xor_a: assert property (
        take && op == OP_LXOR |=> acc_r == ($past(acc_r) ^ $past(req_lit))
            && stat_r.carry == $past(cur_carry) && stat_r.nib == $past(stat_r.nib))
        else $error("literal xor wrong");

    file_xor_a: assert property (
        take && op == OP_FXOR |=> fwr_r.data == ($past(acc_r) ^ $past(FILE_RDATA_IN))
            && stat_r.carry == $past(cur_carry))
        else $error("file xor wrong");

    sleep_status_a: assert property (
        go_sleep |=> (WDOG_CLEAR_OUT && stat_r.expiry && !stat_r.pwr_down)
            ##1 (!WDOG_CLEAR_OUT || !$past(CE_IN)))
        else $error("sleep status or watchdog clear wrong");

    halt_hold_a: assert property (
        go_sleep |=> OSC_STOP_OUT && !READY_OUT && state_r == ST_HALT)
        else $error("sleep did not halt");

    halt_stay_a: assert property (
        state_r == ST_HALT && !wake_s2_r && CE_IN |=> state_r == ST_HALT && OSC_STOP_OUT)
        else $error("halt left without wake");

    zero_flag_a: assert property (
        upd_zero |=> stat_r.zero == ((fwr_r.we ? fwr_r.data : acc_r) == 8'h00))
        else $error("zero flag wrong");

    cov_borrow_c: cover property (take && op == OP_FSUBB && !cur_carry);
    cov_sleep_wake_c: cover property (go_sleep ##[1:20] state_r == ST_RUN);
    cov_dir_c_c: cover property (dir_ld && req_addr == DIR_SEL_C);
    cov_zero_c: cover property (upd_zero && res_zero);
endmodule

// ===== tb/testbench.sv
// Self-checking testbench for the rotate, subtract, xor, direction and sleep unit
`timescale 1ns/1ns
module testbench;
    import arsx_pkg::*;
    logic clk, rst, ce, wake, ready, osc_stop, wdog_clr;
    arsx_req_t req;
    logic [7:0] frd, acc, dir_a, dir_b, dir_c, acc_e;
    logic [7:0] dir_e[8];
    arsx_stat_t stat, st_e;
    arsx_fwr_t fwr;
    int mismatches, total_checks;

    arsx_exec DUT (.CORE_CLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .REQ_IN(req),
        .FILE_RDATA_IN(frd), .WAKE_IN(wake), .READY_OUT(ready), .ACC_OUT(acc),
        .STATUS_OUT(stat), .FILE_WR_OUT(fwr), .PORT_A_DIR_OUT(dir_a),
        .PORT_B_DIR_OUT(dir_b), .PORT_C_DIR_OUT(dir_c), .WDOG_CLEAR_OUT(wdog_clr),
        .OSC_STOP_OUT(osc_stop));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // One request taken on the second edge; results sampled just after it
    task automatic run(input arsx_op_t op, input logic [6:0] fa, input logic d,
                       input logic [7:0] k, input logic [7:0] fv);
        @(posedge clk);
        req <= '{valid: 1'b1, op: op, faddr: fa, dest: d, lit: k};
        frd <= fv;
        @(posedge clk);
        req.valid <= 1'b0;
        #1;
    endtask

    task automatic dest_chk(input logic d, input logic [6:0] fa, input logic [7:0] v);
        if (d) begin
            chk({fwr.we, fwr.addr, fwr.data}, {1'b1, fa, v}, "file write");
        end else begin
            acc_e = v;
            chk(fwr.we, 1'b0, "stray file write");
        end
        chk(acc, acc_e, "accumulator");
        chk(stat, st_e, "status");
    endtask

    task automatic set_acc(input logic [7:0] w);
        run(OP_LXOR, 7'h00, 1'b0, acc_e ^ w, 8'h00);
        st_e.zero = (w == 8'h00);
        dest_chk(1'b0, 7'h00, w);
    endtask

    task automatic t_reset();
        chk(acc, 8'h00, "reset accumulator");
        chk(stat, st_e, "reset status");
        chk({ready, osc_stop, wdog_clr, fwr.we}, 4'b1000, "reset control");
        chk({dir_a, dir_b}, 16'hffff, "reset directions");
    endtask

    task automatic t_lsub();
        logic [7:0] ws[3] = '{8'h35, 8'h34, 8'h0f};
        logic [7:0] ks[3] = '{8'h34, 8'h34, 8'hf0};
        foreach (ws[i]) begin
            set_acc(ws[i]);
            run(OP_LSUB, 7'h7f, 1'b1, ks[i], 8'h00);
            st_e.carry = ws[i] <= ks[i];
            st_e.nib = ws[i][3:0] <= ks[i][3:0];
            st_e.zero = ks[i] == ws[i];
            dest_chk(1'b0, 7'h00, ks[i] - ws[i]);
        end
    endtask

    task automatic t_fsub();
        arsx_op_t ops[5] = '{OP_FSUB, OP_FSUB, OP_FSUBB, OP_FSUBB, OP_FSUBB};
        logic ds[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
        logic [7:0] ws[5] = '{8'h12, 8'h34, 8'h10, 8'h05, 8'h05};
        logic [7:0] fs[5] = '{8'h34, 8'h12, 8'h10, 8'h20, 8'h05};
        logic b;
        logic [8:0] r9;
        logic [4:0] r5;
        foreach (ws[i]) begin
            set_acc(ws[i]);
            b = (ops[i] == OP_FSUBB) ? ~st_e.carry : 1'b0;
            run(ops[i], 7'h40 + 7'(i), ds[i], 8'h00, fs[i]);
            r9 = {1'b0, fs[i]} - {1'b0, ws[i]} - {8'h00, b};
            r5 = {1'b0, fs[i][3:0]} - {1'b0, ws[i][3:0]} - {4'h0, b};
            st_e.carry = ~r9[8];
            st_e.nib = ~r5[4];
            st_e.zero = r9[7:0] == 8'h00;
            dest_chk(ds[i], 7'h40 + 7'(i), r9[7:0]);
        end
    endtask

    task automatic t_ror_swap_xor();
        logic [7:0] fs[3] = '{8'h81, 8'h02, 8'h01};
        logic [7:0] v;
        foreach (fs[i]) begin
            run(OP_ROR, 7'h7f, i[0], 8'h00, fs[i]);
            v = {st_e.carry, fs[i][7:1]};
            st_e.carry = fs[i][0];
            dest_chk(i[0], 7'h7f, v);
            run(OP_SWAP, 7'h00, ~i[0], 8'h00, fs[i] + 8'ha4);
            v = fs[i] + 8'ha4;
            dest_chk(~i[0], 7'h00, {v[3:0], v[7:4]});
            v = (i == 1) ? acc_e : fs[i];
            run(OP_FXOR, 7'h11, i[0], 8'h00, v);
            st_e.zero = (acc_e ^ v) == 8'h00;
            dest_chk(i[0], 7'h11, acc_e ^ v);
        end
    endtask

    task automatic t_dir();
        for (int s = 4; s < 8; s++) begin
            set_acc(8'h10 + 8'(s));
            run(OP_DIRLD, 7'(s), 1'b0, 8'h00, 8'h00);
            if (s > 4) begin
                dir_e[s] = acc_e;
            end
            chk({dir_a, dir_b}, {dir_e[5], dir_e[6]}, "direction a b");
            chk(dir_c, dir_e[7], "direction c");
            dest_chk(1'b0, 7'h00, acc_e);
        end
    endtask

    task automatic t_sleep();
        int n;
        @(posedge clk);
        ce <= 1'b0;
        run(OP_LXOR, 7'h00, 1'b0, 8'hff, 8'h00);
        @(posedge clk);
        ce <= 1'b1;
        #1;
        dest_chk(1'b0, 7'h00, acc_e);
        run(OP_SLEEP, 7'h00, 1'b0, 8'h00, 8'h00);
        st_e.expiry = 1'b1;
        st_e.pwr_down = 1'b0;
        chk({ready, osc_stop, wdog_clr}, 3'b011, "sleep entry");
        chk(stat, st_e, "sleep status");
        @(posedge clk);
        #1;
        chk(wdog_clr, 1'b0, "watchdog clear pulse");
        run(OP_LXOR, 7'h00, 1'b0, 8'hff, 8'h00);
        chk({ready, osc_stop, acc}, {2'b01, acc_e}, "halted");
        @(posedge clk);
        wake <= 1'b1;
        for (n = 0; n < 10 && ready !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        wake <= 1'b0;
        chk({ready, osc_stop}, 2'b10, "wake");
        chk(16'(n), 16'h0003, "wake latency");
        chk(stat, st_e, "status after wake");
    endtask

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        mismatches++;
        print_verdict();
    end

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        wake = 1'b0;
        req = '0;
        frd = 8'h00;
        acc_e = 8'h00;
        st_e = 5'b00011;
        foreach (dir_e[i]) dir_e[i] = 8'hff;
        mismatches = 0;
        total_checks = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1;
        t_reset();
        set_acc(8'hff);
        t_lsub();
        t_fsub();
        t_ror_swap_xor();
        t_dir();
        t_sleep();
        print_verdict();
    end
endmodule
